// File: bps_cfg.svh
// timing counts, register offsets and field positions of the sequencer
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH
// ----------------------------------------
// time base
// ----------------------------------------
`define BPS_CLK_MHZ         100
`define BPS_TICK_NS         1000
`define BPS_TICK_CYC        (`BPS_TICK_NS * `BPS_CLK_MHZ / 1000)
`define BPS_TON_MIN_NS      125
`define BPS_TON_MIN_CYC     ((`BPS_TON_MIN_NS * `BPS_CLK_MHZ + 999) / 1000)
`define BPS_MODE_DELAY_US   30
`define BPS_MODE_DELAY_TICK (`BPS_MODE_DELAY_US * 1000 / `BPS_TICK_NS)
`define BPS_GOOD_DELAY_NS   25000
`define BPS_GOOD_DELAY_TICK (`BPS_GOOD_DELAY_NS / `BPS_TICK_NS)
`define BPS_SYNC_HOLD_US    10
`define BPS_COOLDOWN_US     75000
`define BPS_OCP_PULSES      128
`define BPS_OSC_KHZ         450
// ----------------------------------------
// register map
// ----------------------------------------
`define BPS_REG_CTRL        8'h00
`define BPS_REG_STATUS      8'h04
`define BPS_REG_INT_STAT    8'h08
`define BPS_REG_INT_MASK    8'h0C
`define BPS_CTRL_RST        1'b1
`define BPS_MASK_RST        5'h00
`define BPS_ST_GATE         3
`define BPS_ST_SYNC         4
`define BPS_ST_GOOD         5
`define BPS_ST_SUPPLY       6
`define BPS_ST_GOOD_PIN     7
`define BPS_ST_OCCNT_LSB    8
`define BPS_IRQ_HICCUP      0
`define BPS_IRQ_THERMAL     1
`define BPS_IRQ_LOCKOUT     2
`define BPS_IRQ_GOOD_LOST   3
`define BPS_IRQ_STANDBY     4
`endif

// File: bps_pkg.sv
// types shared by the sequencer modules
package bps_pkg;
  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_STANDBY = 3'h1,
    ST_RUN     = 3'h3,
    ST_HICCUP  = 3'h2,
    ST_THERMAL = 3'h6
  } bps_state_t;

  // synchronised condition inputs
  typedef struct packed {
    logic sup_on;
    logic sup_low;
    logic oc;
    logic pwm_off;
    logic fbk_low;
    logic fbk_over;
    logic fbk_under;
    logic t_hot;
    logic t_cool;
    logic en;
    logic good_in;
  } bps_pins_t;

  typedef struct packed {
    bps_state_t  st;
    logic [6:0]  pre;
    logic        tick;
    logic [15:0] osc;
    logic        gate_on;
    logic [7:0]  on_cnt;
    logic        oc_hit;
    logic [7:0]  oc_cnt;
    logic [23:0] cool;
    logic        uv_ok;
    logic        hot;
    logic        en_d;
    logic [3:0]  recent;
    logic        ss_dis;
    logic        good_oe;
    logic        run_en;
    logic [4:0]  irq_st;
    logic [4:0]  irq_msk;
    logic        irq;
    logic        ack;
    logic [31:0] rdat;
  } bps_core_t;
endpackage

// File: bps_sync2.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module bps_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } bps_sync_t;

  bps_sync_t s_r;
  bps_sync_t s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt.ff1 = d;
    s_nxt.ff2 = s_r.ff1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.ff2;
endmodule

// File: bps_deglitch.sv
// level filter: output follows input after N steady time-base ticks
`timescale 1ns/1ps
module bps_deglitch #(
  parameter int   N    = 30,
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // time base and level
  input  wire logic tick,
  input  wire logic level,
  output logic      out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        lvl;
  } bps_dg_t;

  localparam logic [15:0] LIM = 16'(N - 1);

  bps_dg_t d_r;
  bps_dg_t d_nxt;

  // any return to the held level restarts the count
  always_comb begin
    d_nxt = d_r;
    if (level == d_r.lvl) begin
      d_nxt.cnt = 16'h0000;
    end else if (tick) begin
      if (d_r.cnt == LIM) begin
        d_nxt.lvl = level;
        d_nxt.cnt = 16'h0000;
      end else begin
        d_nxt.cnt = d_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_r <= '{cnt: 16'h0000, lvl: INIT};
    end else begin
      d_r <= d_nxt;
    end
  end

  assign out = d_r.lvl;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_filter_delay: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(d_r.lvl) |-> $past(d_r.cnt) == LIM && $past(tick))
    else $error("filtered level changed before its delay");
endmodule

// File: bps_top.sv
// protection and start-up sequencer for a step-down regulator
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "bps_cfg.svh"
module bps_top
  import bps_pkg::*;
#(
  parameter int COOLDOWN_US = `BPS_COOLDOWN_US,
  parameter int OSC_KHZ     = `BPS_OSC_KHZ,
  parameter int OCP_PULSES  = `BPS_OCP_PULSES
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // condition comparators
  input  wire logic        SUPPLY_ON,
  input  wire logic        SUPPLY_LOW,
  input  wire logic        OVERCURRENT_GUARD,
  input  wire logic        PWM_OFF,
  input  wire logic        FEEDBACK_SENSE_LOW,
  input  wire logic        FEEDBACK_SENSE_OVER,
  input  wire logic        FEEDBACK_SENSE_UNDER,
  input  wire logic        THERMAL_CUTOUT_HOT,
  input  wire logic        THERMAL_CUTOUT_COOL,
  input  wire logic        EN_SYNC,
  // open-drain output-good pin
  input  wire logic        OUTPUT_GOOD_FLAG_I,
  output logic             OUTPUT_GOOD_FLAG_O,
  output logic             OUTPUT_GOOD_FLAG_OE,
  // power stage and interrupt
  output logic             SWITCH_ON,
  output logic             SS_DISCHARGE,
  output logic             IRQ
);
  localparam int          OSC_CYC  = `BPS_CLK_MHZ * 1000 / OSC_KHZ;
  localparam logic [15:0] OSC_LOAD = 16'(OSC_CYC - 1);
  localparam logic [6:0]  PRE_LIM  = 7'(`BPS_TICK_CYC - 1);
  localparam logic [7:0]  TON_LIM  = 8'(`BPS_TON_MIN_CYC - 1);
  localparam logic [7:0]  OCP_LIM  = 8'(OCP_PULSES - 1);
  localparam logic [23:0] COOL_LD  = 24'(COOLDOWN_US * 1000 / `BPS_TICK_NS - 1);
  localparam logic [3:0]  HOLD_LD  = 4'(`BPS_SYNC_HOLD_US);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_q;
  logic       rst_n;

  // assert at once, release after two edges
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  bps_pins_t pin_raw;
  bps_pins_t pins;

  assign pin_raw = '{sup_on: SUPPLY_ON, sup_low: SUPPLY_LOW,
                     oc: OVERCURRENT_GUARD, pwm_off: PWM_OFF,
                     fbk_low: FEEDBACK_SENSE_LOW, fbk_over: FEEDBACK_SENSE_OVER,
                     fbk_under: FEEDBACK_SENSE_UNDER, t_hot: THERMAL_CUTOUT_HOT,
                     t_cool: THERMAL_CUTOUT_COOL, en: EN_SYNC,
                     good_in: OUTPUT_GOOD_FLAG_I};

  bps_sync2 #(.W($bits(bps_pins_t))) u_sync (
    .clk   (MCLK),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pins)
  );

  // ----------------------------------------
  // filtered mode levels
  // ----------------------------------------
  bps_core_t q;
  bps_core_t nxt;
  logic      en_on;
  logic      sync_mode;
  logic      good_ok;

  // sync low phases are far shorter than the delay, so standby ignores them
  bps_deglitch #(.N(`BPS_MODE_DELAY_TICK), .INIT(1'b0)) u_stby (
    .clk   (MCLK),
    .rst_n (rst_n),
    .tick  (q.tick),
    .level (pins.en),
    .out   (en_on)
  );

  bps_deglitch #(.N(`BPS_MODE_DELAY_TICK), .INIT(1'b0)) u_mode (
    .clk   (MCLK),
    .rst_n (rst_n),
    .tick  (q.tick),
    .level (q.recent != 4'h0),
    .out   (sync_mode)
  );

  bps_deglitch #(.N(`BPS_GOOD_DELAY_TICK), .INIT(1'b0)) u_good (
    .clk   (MCLK),
    .rst_n (rst_n),
    .tick  (q.tick),
    .level (!pins.fbk_over && !pins.fbk_under),
    .out   (good_ok)
  );

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  function automatic logic [31:0] reg_read(input logic [7:0] a, input bps_core_t s,
                                           input logic [31:0] stat);
    case (a)
      `BPS_REG_CTRL:     reg_read = {31'h0000_0000, s.run_en};
      `BPS_REG_STATUS:   reg_read = stat;
      `BPS_REG_INT_STAT: reg_read = {27'h000_0000, s.irq_st};
      `BPS_REG_INT_MASK: reg_read = {27'h000_0000, s.irq_msk};
      default:           reg_read = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic        rise;
  logic        start;
  logic        stop_req;
  logic        hiccup_hit;
  logic [31:0] stat;
  logic [4:0]  ev;
  logic        wr;

  always_comb begin
    nxt = q;
    rise = pins.en && !q.en_d;
    nxt.en_d = pins.en;
    // fixed time base, never derived from the sync pin
    nxt.tick = (q.pre == PRE_LIM);
    nxt.pre = nxt.tick ? 7'h00 : q.pre + 7'h01;
    // supply and thermal hysteresis latches
    if (pins.sup_on) begin
      nxt.uv_ok = 1'b1;
    end else if (pins.sup_low) begin
      nxt.uv_ok = 1'b0;
    end
    if (pins.t_hot) begin
      nxt.hot = 1'b1;
    end else if (pins.t_cool) begin
      nxt.hot = 1'b0;
    end
    // recent rising edges mean an external clock is present
    if (rise) begin
      nxt.recent = HOLD_LD;
    end else if (q.tick && q.recent != 4'h0) begin
      nxt.recent = q.recent - 4'h1;
    end
    // cycle start: own oscillator, or the sync edge
    start = sync_mode ? rise : (q.osc == 16'h0000);
    nxt.osc = (q.osc == 16'h0000 || (sync_mode && rise)) ? OSC_LOAD : q.osc - 16'h0001;
    // gate control inside a cycle
    hiccup_hit = q.gate_on && pins.oc && pins.fbk_low && q.oc_cnt == OCP_LIM;
    if (q.gate_on && q.on_cnt != 8'hFF) begin
      nxt.on_cnt = q.on_cnt + 8'h01;
    end
    if (start) begin
      nxt.gate_on = 1'b1;
      nxt.on_cnt = 8'h00;
      nxt.oc_hit = 1'b0;
      if (!q.oc_hit) begin
        nxt.oc_cnt = 8'h00;
      end
    end else if (q.gate_on) begin
      if (pins.oc) begin
        // current limit overrides the minimum on time
        nxt.gate_on = 1'b0;
        nxt.oc_hit = 1'b1;
        if (pins.fbk_low) begin
          nxt.oc_cnt = q.oc_cnt + 8'h01;
        end
      end else if (pins.pwm_off && q.on_cnt >= TON_LIM) begin
        nxt.gate_on = 1'b0;
      end
    end
    if (!pins.fbk_low) begin
      nxt.oc_cnt = 8'h00;
    end
    // mode sequencing
    stop_req = !en_on || !q.run_en;
    unique case (q.st)
      ST_OFF: begin
        if (q.uv_ok) nxt.st = ST_STANDBY;
      end
      ST_STANDBY: begin
        if (!stop_req) nxt.st = q.hot ? ST_THERMAL : ST_RUN;
      end
      ST_RUN: begin
        if (hiccup_hit) begin
          nxt.st = ST_HICCUP;
          nxt.cool = COOL_LD;
        end else if (q.hot) begin
          nxt.st = ST_THERMAL;
        end
      end
      ST_HICCUP: begin
        if (q.tick) begin
          if (q.cool == 24'h00_0000) nxt.st = ST_RUN;
          else nxt.cool = q.cool - 24'h00_0001;
        end
      end
      ST_THERMAL: begin
        if (!q.hot) nxt.st = ST_RUN;
      end
      default: nxt.st = ST_OFF;
    endcase
    if (!q.uv_ok) begin
      nxt.st = ST_OFF;
    end else if (stop_req && q.st != ST_OFF) begin
      nxt.st = ST_STANDBY;
    end
    if (nxt.st != ST_RUN) begin
      nxt.gate_on = 1'b0;
      nxt.oc_cnt = 8'h00;
      nxt.oc_hit = 1'b0;
    end
    // discharge held the whole time switching is stopped
    nxt.ss_dis = (nxt.st != ST_RUN);
    nxt.good_oe = !good_ok;
    // events; set wins over a clear in the same cycle
    ev = '0;
    ev[`BPS_IRQ_HICCUP] = nxt.st == ST_HICCUP && q.st != ST_HICCUP;
    ev[`BPS_IRQ_THERMAL] = nxt.st == ST_THERMAL && q.st != ST_THERMAL;
    ev[`BPS_IRQ_LOCKOUT] = nxt.st == ST_OFF && q.st != ST_OFF;
    ev[`BPS_IRQ_GOOD_LOST] = nxt.good_oe && !q.good_oe;
    ev[`BPS_IRQ_STANDBY] = nxt.st == ST_STANDBY && q.st != ST_STANDBY;
    stat = {16'h0000, q.oc_cnt, pins.good_in, q.uv_ok, good_ok, sync_mode, q.gate_on, q.st};
    // wishbone: ack one cycle after the request, write at the ack edge
    wr = q.ack && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
    nxt.ack = WB_CYC_I && WB_STB_I && !q.ack;
    nxt.rdat = nxt.ack ? reg_read(WB_ADR_I, q, stat) : 32'h0000_0000;
    nxt.irq_st = q.irq_st | ev;
    if (wr && WB_ADR_I == `BPS_REG_CTRL) nxt.run_en = WB_DAT_I[0];
    if (wr && WB_ADR_I == `BPS_REG_INT_MASK) nxt.irq_msk = WB_DAT_I[4:0];
    if (wr && WB_ADR_I == `BPS_REG_INT_STAT) nxt.irq_st = (q.irq_st & ~WB_DAT_I[4:0]) | ev;
    nxt.irq = |(nxt.irq_st & nxt.irq_msk);
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= ST_OFF;
      q.osc <= OSC_LOAD;
      q.ss_dis <= 1'b1;
      q.good_oe <= 1'b1;
      q.run_en <= `BPS_CTRL_RST;
      q.irq_msk <= `BPS_MASK_RST;
    end else begin
      q <= nxt;
    end
  end

  // ----------------------------------------
  // outputs, all from flip-flops except OUTPUT_GOOD_FLAG_O, which is tied low
  // ----------------------------------------
  assign SWITCH_ON = q.gate_on;
  assign SS_DISCHARGE = q.ss_dis;
  assign OUTPUT_GOOD_FLAG_OE = q.good_oe;
  assign OUTPUT_GOOD_FLAG_O = 1'b0;
  assign IRQ = q.irq;
  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.rdat;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  chk_lockout_stop: assert property (
    !q.uv_ok |=> q.st == ST_OFF && !SWITCH_ON)
    else $error("switching while supply locked out");
  chk_oc_cut: assert property (
    q.gate_on && pins.oc && !start |=> !SWITCH_ON)
    else $error("gate not cut on overcurrent");
  chk_hiccup_entry: assert property (
    q.st == ST_RUN && hiccup_hit && q.uv_ok && !stop_req |=> q.st == ST_HICCUP ##0 !SWITCH_ON)
    else $error("no hiccup after overcurrent run");
  chk_cooldown_hold: assert property (
    q.st == ST_HICCUP && q.cool != 24'h00_0000 && q.uv_ok && !stop_req |=> q.st == ST_HICCUP)
    else $error("hiccup left before cool-down");
  chk_ss_discharge: assert property (
    q.st != ST_RUN |-> SS_DISCHARGE && !SWITCH_ON)
    else $error("soft start not discharged while stopped");
  chk_thermal_hold: assert property (
    q.st == ST_THERMAL && q.hot |=> q.st != ST_RUN)
    else $error("restart while still hot");
  chk_standby_entry: assert property (
    !en_on && q.uv_ok |=> q.st == ST_STANDBY)
    else $error("standby not entered");
  chk_sync_start: assert property (
    sync_mode && rise && q.st == ST_RUN && q.uv_ok && !stop_req && !q.hot && !hiccup_hit
    |=> SWITCH_ON)
    else $error("sync edge did not start a cycle");
  chk_min_on: assert property (
    $fell(q.gate_on) && q.st == ST_RUN && !$past(pins.oc) |-> $past(q.on_cnt) >= TON_LIM)
    else $error("on pulse shorter than minimum");
  chk_oc_clear: assert property (
    !pins.fbk_low |=> q.oc_cnt == 8'h00)
    else $error("overcurrent count not cleared");
  chk_good_pin: assert property (
    good_ok |=> !OUTPUT_GOOD_FLAG_OE)
    else $error("good pin driven while in window");

  cov_hiccup: cover property (q.st == ST_HICCUP ##1 q.st == ST_RUN);
  cov_thermal: cover property (q.st == ST_THERMAL);
  cov_sync: cover property (sync_mode && q.gate_on);
  cov_good: cover property ($fell(q.good_oe));
endmodule

// File: bps_stage_model.sv
// behavioural power stage, current comparator and enable/sync source
`timescale 1ns/1ps
module bps_stage_model (
  // clock
  input  wire logic       clk,
  // bench controls
  input  wire logic       oc_mode,
  input  wire logic [7:0] on_len,
  input  wire logic       en_lvl,
  input  wire logic       sync_on,
  // sequencer side
  input  wire logic       gate,
  input  wire logic       good_o,
  input  wire logic       good_oe,
  output logic            oc,
  output logic            pwm_off,
  output logic            en_sync,
  output logic            good_pin
);
  logic [7:0] on_r = 8'h00;
  logic [7:0] ph_r = 8'h00;

  // external pull-up wins unless the sequencer sinks the pin
  assign good_pin = good_oe ? good_o : 1'b1;

  // comparators only see current while the switch conducts; unknown only before the first edge, inside reset
  always @(posedge clk) begin
    on_r <= gate ? on_r + 8'h01 : 8'h00;
    oc <= oc_mode & gate;
    pwm_off <= gate & (on_r >= on_len);
    ph_r <= (ph_r == 8'hC7) ? 8'h00 : ph_r + 8'h01;
    // 500 kHz, half duty: inside the fixed-rate band
    en_sync <= sync_on ? (ph_r < 8'h64) : en_lvl;
  end
endmodule

// File: bps_top_tb.sv
// self-checking bench for the protection and start-up sequencer
`timescale 1ns/1ps
module bps_top_tb
  import bps_pkg::*;
;
  localparam int TICK = 100;         // cycles per time-base tick
  localparam int COOL = 50;          // shortened cool-down in ticks
  localparam int NOC  = 4;           // shortened overcurrent run
  localparam int OSC  = 100000 / 450;
  logic        MCLK = 1'b0, RESETN = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00, on_len = 8'h28;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
  logic        WB_ACK_O, SWITCH_ON, SS_DISCHARGE, IRQ, OVERCURRENT_GUARD, PWM_OFF, EN_SYNC;
  logic        SUPPLY_ON = 1'b0, SUPPLY_LOW = 1'b1, THERMAL_CUTOUT_HOT = 1'b0, THERMAL_CUTOUT_COOL = 1'b1;
  logic        FEEDBACK_SENSE_LOW = 1'b0, FEEDBACK_SENSE_OVER = 1'b0, FEEDBACK_SENSE_UNDER = 1'b1;
  logic        OUTPUT_GOOD_FLAG_I, OUTPUT_GOOD_FLAG_O, OUTPUT_GOOD_FLAG_OE;
  logic        oc_mode = 1'b0, en_lvl = 1'b0, sync_on = 1'b0;
  int          cyc_n = 0, checked = 0, miscompares = 0;

  bps_top #(.COOLDOWN_US(COOL), .OCP_PULSES(NOC)) dut (
    .MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'hF), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .SUPPLY_ON(SUPPLY_ON), .SUPPLY_LOW(SUPPLY_LOW), .OVERCURRENT_GUARD(OVERCURRENT_GUARD), .PWM_OFF(PWM_OFF),
    .FEEDBACK_SENSE_LOW(FEEDBACK_SENSE_LOW), .FEEDBACK_SENSE_OVER(FEEDBACK_SENSE_OVER),
    .FEEDBACK_SENSE_UNDER(FEEDBACK_SENSE_UNDER), .THERMAL_CUTOUT_HOT(THERMAL_CUTOUT_HOT),
    .THERMAL_CUTOUT_COOL(THERMAL_CUTOUT_COOL), .EN_SYNC(EN_SYNC), .OUTPUT_GOOD_FLAG_I(OUTPUT_GOOD_FLAG_I),
    .OUTPUT_GOOD_FLAG_O(OUTPUT_GOOD_FLAG_O), .OUTPUT_GOOD_FLAG_OE(OUTPUT_GOOD_FLAG_OE),
    .SWITCH_ON(SWITCH_ON), .SS_DISCHARGE(SS_DISCHARGE), .IRQ(IRQ));

  bps_stage_model stage (
    .clk(MCLK), .oc_mode(oc_mode), .on_len(on_len), .en_lvl(en_lvl), .sync_on(sync_on),
    .gate(SWITCH_ON), .good_o(OUTPUT_GOOD_FLAG_O), .good_oe(OUTPUT_GOOD_FLAG_OE),
    .oc(OVERCURRENT_GUARD), .pwm_off(PWM_OFF), .en_sync(EN_SYNC), .good_pin(OUTPUT_GOOD_FLAG_I));

  // clock and cycle count
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) cyc_n <= cyc_n + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // classic single cycle: hold everything until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge MCLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    q = WB_DAT_O;
    chk(n < 50, "no ack");
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // poll status until masked bits match; n is cycles spent
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v, input int lim, output int n);
    logic [31:0] q;
    int t0;
    t0 = cyc_n;
    do rd(8'h04, q); while ((q & m) !== v && cyc_n - t0 < lim);
    n = cyc_n - t0;
    chk((q & m) === v, "state not reached");
  endtask

  // gap to the next gate rise, then its width in cycles
  task automatic pulse(output int g, output int w);
    g = 0;
    w = 0;
    while (SWITCH_ON === 1'b1) @(posedge MCLK);
    while (SWITCH_ON !== 1'b1 && g < 800) begin
      @(posedge MCLK);
      g++;
    end
    while (SWITCH_ON === 1'b1 && w < 800) begin
      @(posedge MCLK);
      w++;
    end
    chk(g < 800 && w < 800, "no gate pulse");
  endtask

  task automatic wait_oe(input logic v, output int n);
    n = 0;
    while (OUTPUT_GOOD_FLAG_OE !== v && n < 4000) begin
      @(posedge MCLK);
      n++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    chk(SWITCH_ON === 1'b0 && SS_DISCHARGE === 1'b1 && OUTPUT_GOOD_FLAG_OE === 1'b1, "idle pins");
    rd(8'h00, q);
    chk(q === 32'h1, "ctrl reset");
    rd(8'h0C, q);
    chk(q === 32'h0, "mask reset");
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, q);
    chk(q === 32'h0, "unmapped");
    rd(8'h04, q);
    chk(q[2:0] === ST_OFF && q[6] === 1'b0 && IRQ === 1'b0, "lockout idle");
    $display("reset test done");
  endtask

  task automatic t_start();
    int n;
    SUPPLY_LOW <= 1'b0;
    SUPPLY_ON <= 1'b1;
    wait_st(32'h7, {29'h0, ST_STANDBY}, 200, n);
    chk(SS_DISCHARGE === 1'b1, "ss in standby");
    SUPPLY_ON <= 1'b0;
    en_lvl <= 1'b1;
    wait_st(32'h7, {29'h0, ST_RUN}, 4000, n);
    chk(n >= 30 * TICK - 100 && n <= 33 * TICK, "enable delay");
    chk(SS_DISCHARGE === 1'b0, "ss released");
    $display("start test done");
  endtask

  task automatic t_switch();
    logic [31:0] q;
    int g, w, g2, w2;
    on_len <= 8'h00;
    pulse(g, w);
    pulse(g, w);
    chk(w >= 13 && w <= 16, "min on");
    on_len <= 8'h64;
    oc_mode <= 1'b1;
    pulse(g, w);
    pulse(g, w);
    pulse(g2, w2);
    chk(w2 <= 6 && w + g2 >= OSC - 4 && w + g2 <= OSC + 4, "oc cut");
    rd(8'h04, q);
    chk(q[15:8] === 8'h00, "no count");
    oc_mode <= 1'b0;
    $display("switching test done");
  endtask

  task automatic t_hiccup();
    logic [31:0] q;
    int g, w, n;
    wr(8'h08, 32'h1F);
    wr(8'h0C, 32'h01);
    pulse(g, w);
    FEEDBACK_SENSE_LOW <= 1'b1;
    oc_mode <= 1'b1;
    pulse(g, w);
    rd(8'h04, q);
    chk(q[15:8] === 8'h01, "count one");
    oc_mode <= 1'b0;
    pulse(g, w);
    pulse(g, w);
    rd(8'h04, q);
    chk(q[15:8] === 8'h00, "clean clears");
    oc_mode <= 1'b1;
    repeat (NOC - 1) pulse(g, w);
    rd(8'h04, q);
    chk(q[2:0] === ST_RUN && q[15:8] === 8'(NOC - 1), "not yet");
    wait_st(32'h7, {29'h0, ST_HICCUP}, 400, n);
    chk(SWITCH_ON === 1'b0 && SS_DISCHARGE === 1'b1 && IRQ === 1'b1, "hiccup stop");
    oc_mode <= 1'b0;
    FEEDBACK_SENSE_LOW <= 1'b0;
    wait_st(32'h7, {29'h0, ST_RUN}, 6000, n);
    chk(n >= COOL * TICK - 200 && n <= COOL * TICK + 300, "cool-down");
    // irq follows the mask, sticky bit clears on a written one
    wr(8'h0C, 32'h00);
    rd(8'h08, q);
    chk(q[0] === 1'b1 && IRQ === 1'b0, "masked");
    wr(8'h0C, 32'h01);
    rd(8'h08, q);
    chk(IRQ === 1'b1, "unmasked");
    wr(8'h08, 32'h01);
    rd(8'h08, q);
    chk(q[0] === 1'b0 && IRQ === 1'b0, "cleared");
    $display("hiccup test done");
  endtask

  task automatic t_thermal();
    logic [31:0] q;
    int n;
    THERMAL_CUTOUT_COOL <= 1'b0;
    THERMAL_CUTOUT_HOT <= 1'b1;
    wait_st(32'h7, {29'h0, ST_THERMAL}, 100, n);
    THERMAL_CUTOUT_HOT <= 1'b0;
    repeat (OSC * 2) @(posedge MCLK);
    rd(8'h04, q);
    chk(q[2:0] === ST_THERMAL && SWITCH_ON === 1'b0 && SS_DISCHARGE === 1'b1, "held");
    THERMAL_CUTOUT_COOL <= 1'b1;
    wait_st(32'h7, {29'h0, ST_RUN}, 200, n);
    $display("thermal test done");
  endtask

  task automatic t_good();
    logic [31:0] q;
    int n;
    FEEDBACK_SENSE_UNDER <= 1'b0;
    wait_oe(1'b0, n);
    chk(n >= 20 * TICK && n <= 30 * TICK && OUTPUT_GOOD_FLAG_I === 1'b1, "good rise");
    rd(8'h04, q);
    chk(q[5] === 1'b1 && q[7] === 1'b1, "good status");
    FEEDBACK_SENSE_OVER <= 1'b1;
    wait_oe(1'b1, n);
    chk(n >= 20 * TICK && n <= 30 * TICK, "good fall");
    rd(8'h08, q);
    chk(OUTPUT_GOOD_FLAG_I === 1'b0 && q[3] === 1'b1, "pin low");
    FEEDBACK_SENSE_OVER <= 1'b0;
    $display("good test done");
  endtask

  task automatic t_sync();
    int n, g, w, g2, w2;
    on_len <= 8'h14;
    sync_on <= 1'b1;
    wait_st(32'h10, 32'h10, 6000, n);
    chk(n >= 30 * TICK - 100 && n <= 45 * TICK, "sync entry");
    pulse(g, w);
    pulse(g2, w2);
    chk(w + g2 >= 199 && w + g2 <= 201, "sync period");
    while (EN_SYNC !== 1'b0) @(posedge MCLK);
    while (EN_SYNC !== 1'b1) @(posedge MCLK);
    pulse(g, w);
    chk(g <= 6, "edge start");
    sync_on <= 1'b0;
    wait_st(32'h10, 32'h0, 7000, n);
    chk(n >= 30 * TICK - 100 && n <= 55 * TICK, "sync exit");
    on_len <= 8'h28;
    $display("sync test done");
  endtask

  task automatic t_stop();
    logic [31:0] q;
    int n;
    // run bit low acts as standby, high again resumes at once
    wr(8'h00, 32'h0);
    wait_st(32'h7, {29'h0, ST_STANDBY}, 100, n);
    chk(SWITCH_ON === 1'b0 && SS_DISCHARGE === 1'b1, "run bit stop");
    wr(8'h00, 32'h1);
    wait_st(32'h7, {29'h0, ST_RUN}, 100, n);
    en_lvl <= 1'b0;
    wait_st(32'h7, {29'h0, ST_STANDBY}, 4000, n);
    chk(n >= 30 * TICK - 100 && n <= 33 * TICK, "standby delay");
    rd(8'h08, q);
    chk(q[4] === 1'b1 && SWITCH_ON === 1'b0 && SS_DISCHARGE === 1'b1, "standby");
    SUPPLY_LOW <= 1'b1;
    wait_st(32'h7, {29'h0, ST_OFF}, 100, n);
    SUPPLY_LOW <= 1'b0;
    repeat (100) @(posedge MCLK);
    rd(8'h04, q);
    chk(q[2:0] === ST_OFF && q[6] === 1'b0, "stays off");
    rd(8'h08, q);
    chk(q[2] === 1'b1, "lockout event");
    $display("stop test done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge MCLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_reset();
    t_start();
    t_switch();
    t_hiccup();
    t_thermal();
    t_good();
    t_sync();
    t_stop();
    finish_test();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (80000) @(posedge MCLK);
    chk(1'b0, "watchdog");
    finish_test();
  end
endmodule
